// [hdl/lfosc_core.v]
/*
 oscillator model core: generates the low-frequency output as a toggling
 level inside the system clock domain, with fine tune and post divider.
 assumes enable, tune and divider come from the register file.
*/
`include "lfosc_defs.vh"
module lfosc_core (
	input  wire       ref_clk_i,
	input  wire       rst_n_i,
	input  wire       en_i,
	input  wire [3:0] tune_i,
	input  wire [1:0] div_i,
	output reg        osc_o,
	output reg        raw_tick_o
);
	// half period grows with tune, so 0 is fastest
	wire [31:0] half_wide = `LFOSC_PER_BASE +
		tune_i * `LFOSC_PER_STEP;
	wire [15:0] half = half_wide[15:0];
	reg  [15:0] cnt;
	reg  [2:0]  dcnt;
	// div select 00..11 maps to 8,4,2,1 edges per output toggle
	wire [2:0]  dlim = (3'h7 >> div_i) & 3'h7;

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 16'h0000;
			dcnt <= 3'h0;
			osc_o <= 1'b0;
			raw_tick_o <= 1'b0;
		end else if (!en_i) begin
			cnt <= 16'h0000;
			dcnt <= 3'h0;
			osc_o <= 1'b0;
			raw_tick_o <= 1'b0;
		end else if (cnt >= half - 16'h0001) begin
			cnt <= 16'h0000;
			raw_tick_o <= 1'b1;
			if (dcnt >= dlim) begin
				dcnt <= 3'h0;
				osc_o <= ~osc_o;
			end else begin
				dcnt <= dcnt + 3'h1;
			end
		end else begin
			cnt <= cnt + 16'h0001;
			raw_tick_o <= 1'b0;
		end
	end
endmodule

// [hdl/lfosc_ctrl.v]
/*
 low-frequency oscillator control with timer capture, low-power oscillator
 auto enable and external oscillator pin assignment, on AXI4-Lite.
 assumes one clock; rstn_i may be asynchronous; one access of each kind at
 a time from the master.
*/
`include "lfosc_defs.vh"
module lfosc_ctrl (
	input  wire        ref_clk_i,
	input  wire        rstn_i,
	input  wire [9:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [9:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	input  wire        sysclk_lp_sel_i,
	output reg         lf_osc_o,
	output reg         lp_osc_en_o,
	output reg         crystal_pin_a_en_o,
	output reg         crystal_pin_b_en_o
);
	reg        rs1;
	reg        rst_n;
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rs1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1 <= 1'b1;
			rst_n <= rs1;
		end
	end

	// the select pin may come from another domain
	reg lps1;
	reg lps2;
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lps1 <= 1'b0;
			lps2 <= 1'b0;
		end else begin
			lps1 <= sysclk_lp_sel_i;
			lps2 <= lps1;
		end
	end

	reg        lf_osc_enable;
	reg        lf_osc_ready;
	reg [3:0]  lf_osc_fine_tune;
	reg [1:0]  lf_osc_divider_sel;
	reg [2:0]  xmode;
	reg [2:0]  misc;
	reg [15:0] timer_count [0:1];
	reg [15:0] timer_reload [0:1];
	reg [7:0]  stab;
	reg        osc_d;

	wire       osc;
	wire       tick;
	lfosc_core u_core (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n),
		.en_i       (lf_osc_enable),
		.tune_i     (lf_osc_fine_tune),
		.div_i      (lf_osc_divider_sel),
		.osc_o      (osc),
		.raw_tick_o (tick)
	);

	// write side: address and data may arrive in either order
	reg        aw_got;
	reg        w_got;
	reg [9:0]  aw_q;
	reg [31:0] w_q;
	reg        w_b0;
	// decode on the word index; the two byte-lane bits are ignored
	wire [7:0] aw_idx = aw_q[`LFOSC_IDX_HI:`LFOSC_IDX_LO];
	wire       do_wr = aw_got & w_got & ~s_axi_bvalid_o;
	wire       wr_ctrl = do_wr & (aw_idx == `LFOSC_REG_CTRL) & w_b0;
	wire       wr_x = do_wr & (aw_idx == `LFOSC_REG_XCTRL) & w_b0;
	wire       wr_m = do_wr & (aw_idx == `LFOSC_REG_MISC) & w_b0;
	wire       wr_ok = (aw_idx == `LFOSC_REG_CTRL) |
		(aw_idx == `LFOSC_REG_XCTRL) | (aw_idx == `LFOSC_REG_MISC) |
		(aw_idx == `LFOSC_REG_TMR2) | (aw_idx == `LFOSC_REG_TMR3);
	wire [1:0] new_div = w_q[`LFOSC_F_DIV_HI:`LFOSC_F_DIV_LO];
	wire       div_chg = wr_ctrl & (new_div != lf_osc_divider_sel);
	wire       en_rise = wr_ctrl & w_q[`LFOSC_B_EN] & ~lf_osc_enable;

	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `LFOSC_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= 10'h000;
			w_q <= 32'h00000000;
			w_b0 <= 1'b0;
		end else begin
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_got <= 1'b1;
				aw_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				w_got <= 1'b1;
				w_q <= s_axi_wdata_i;
				w_b0 <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_ok ? `LFOSC_RESP_OKAY :
					`LFOSC_RESP_SLVERR;
			end
			if (s_axi_bvalid_o & s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// control register, ready and stabilization
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lf_osc_enable <= 1'b0;
			lf_osc_fine_tune <= `LFOSC_TUNE_RST;
			lf_osc_divider_sel <= 2'h0;
			lf_osc_ready <= 1'b0;
			stab <= 8'h00;
			xmode <= `LFOSC_XM_OFF;
			misc <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				lf_osc_enable <= w_q[`LFOSC_B_EN];
				// tune taken as written; software keeps it still while on
				lf_osc_fine_tune <=
					w_q[`LFOSC_F_TUNE_HI:`LFOSC_F_TUNE_LO];
				lf_osc_divider_sel <= new_div;
			end
			if (wr_x)
				xmode <= w_q[`LFOSC_XMODE_HI:`LFOSC_XMODE_LO];
			if (wr_m)
				misc <= w_q[2:0];
			if (div_chg) begin
				lf_osc_ready <= 1'b0;
				stab <= 8'h00;
			end else if (en_rise) begin
				stab <= 8'h00;
			end else if (lf_osc_enable & tick & ~lf_osc_ready) begin
				if (stab >= `LFOSC_STAB_CYC - 8'h01)
					lf_osc_ready <= 1'b1;
				else
					stab <= stab + 8'h01;
			end
		end
	end

	// timers count system clocks and capture on oscillator edges
	wire [1:0] cap_ev;
	assign cap_ev[0] = misc[`LFOSC_M_CAP2] & osc_d & ~osc;
	assign cap_ev[1] = misc[`LFOSC_M_CAP3] & ~osc_d & osc;
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n)
			osc_d <= 1'b0;
		else
			osc_d <= osc;
	end
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_tmr
			always @(posedge ref_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					timer_count[g] <= 16'h0000;
					timer_reload[g] <= 16'h0000;
				end else begin
					timer_count[g] <= timer_count[g] + 16'h0001;
					if (cap_ev[g])
						timer_reload[g] <= timer_count[g];
				end
			end
		end
	endgenerate

	// outputs and pin assignment
	wire xtal = (xmode == `LFOSC_XM_XTAL) | (xmode == `LFOSC_XM_CRYSTAL_PIN_B);
	wire xone = (xmode == `LFOSC_XM_CMOS) | (xmode == `LFOSC_XM_CMOS2) |
		(xmode == `LFOSC_XM_RC) | (xmode == `LFOSC_XM_CAP);
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lf_osc_o <= 1'b0;
			lp_osc_en_o <= 1'b0;
			crystal_pin_a_en_o <= 1'b0;
			crystal_pin_b_en_o <= 1'b0;
		end else begin
			lf_osc_o <= osc;
			lp_osc_en_o <= lps2 | misc[`LFOSC_M_LPSEL];
			crystal_pin_a_en_o <= xtal;
			crystal_pin_b_en_o <= xtal | xone;
		end
	end

	// read side, one cycle after address
	reg [31:0] rd;
	reg        rd_ok;
	always @* begin
		rd = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr_i[`LFOSC_IDX_HI:`LFOSC_IDX_LO])
			`LFOSC_REG_CTRL:
				rd = {24'h000000, lf_osc_enable, lf_osc_ready,
					lf_osc_fine_tune, lf_osc_divider_sel};
			`LFOSC_REG_XCTRL:
				rd = {25'h0000000, xmode, 4'h0};
			`LFOSC_REG_TMR2:
				rd = {timer_count[0], timer_reload[0]};
			`LFOSC_REG_TMR3:
				rd = {timer_count[1], timer_reload[1]};
			`LFOSC_REG_MISC:
				rd = {29'h00000000, misc};
			default:
				rd_ok = 1'b0;
		endcase
	end
	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `LFOSC_RESP_OKAY;
		end else if (s_axi_arvalid_i & s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd;
			s_axi_rresp_o <= rd_ok ? `LFOSC_RESP_OKAY : `LFOSC_RESP_SLVERR;
		end else if (s_axi_rvalid_o & s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
endmodule

// [hdl/lfosc_defs.vh]
/*
 low-frequency oscillator control block: constants, register map, field
 positions and timing counts.
 assumes a 250 MHz system clock and an AXI4-Lite master on the bus side.
*/
// Behaviour
// - the oscillator runs only while the enable bit is 1 and is held off while it is 0.
// - the two-bit divider select picks divide by 8, 4, 2 or 1 for codes 00, 01, 10, 11.
// - the read-only ready flag reads 1 once stable and is cleared only by reset or a write that changes the divider select.
// - in capture mode timer 2 captures on each falling oscillator edge and timer 3 on each rising edge.
// - on a capture event the timer's 16-bit count is copied into its reload register pair.
// - the low-power oscillator is enabled whenever it is the system clock source or the misc LFOSC_M_LPSEL bit is set, and disabled otherwise.
// - in crystal or resonator mode pins P0.2 and P0.3 are the two crystal connections.
// - in capacitor, RC or CMOS clock mode only pin P0.3 is the oscillator connection.
`ifndef LFOSC_DEFS_VH
`define LFOSC_DEFS_VH

// register constants are word indices; the byte address is four times one
`define LFOSC_ADDR_W        10
`define LFOSC_IDX_HI        9
`define LFOSC_IDX_LO        2
`define LFOSC_REG_CTRL      8'he3
`define LFOSC_REG_XCTRL     8'he4
`define LFOSC_REG_TMR2      8'he8
`define LFOSC_REG_TMR3      8'hec
`define LFOSC_REG_MISC      8'hf0

`define LFOSC_B_EN          7
`define LFOSC_B_RDY         6
`define LFOSC_F_TUNE_HI     5
`define LFOSC_F_TUNE_LO     2
`define LFOSC_F_DIV_HI      1
`define LFOSC_F_DIV_LO      0
`define LFOSC_CTRL_RST      8'h00
`define LFOSC_TUNE_RST      4'h8

`define LFOSC_XMODE_HI      6
`define LFOSC_XMODE_LO      4
`define LFOSC_XM_OFF        3'h0
`define LFOSC_XM_CMOS       3'h2
`define LFOSC_XM_CMOS2      3'h3
`define LFOSC_XM_RC         3'h4
`define LFOSC_XM_CAP        3'h5
`define LFOSC_XM_XTAL       3'h6
`define LFOSC_XM_CRYSTAL_PIN_B      3'h7

`define LFOSC_M_CAP2        0
`define LFOSC_M_CAP3        1
`define LFOSC_M_LPSEL       2

`define LFOSC_NOM_KHZ       80
`define LFOSC_CLK_KHZ       250000
`define LFOSC_PER_BASE      ((`LFOSC_CLK_KHZ / `LFOSC_NOM_KHZ) / 2)
`define LFOSC_PER_STEP      8
`define LFOSC_STAB_CYC      8'h10

`define LFOSC_RESP_OKAY     2'h0
`define LFOSC_RESP_SLVERR   2'h2
`endif

// [tb/lfosc_ctrl_bench.sv]
/*
 self-checking bench for lfosc_ctrl: register reads go through an
 expectation queue checked by a monitor; pins, low-power enable and
 oscillator timing are checked in the main sequence.
 assumes lfosc_defs.vh on the include path; bready, rready, wstrb held.
*/
`include "lfosc_defs.vh"
`define CHK(nm, ex, sn) begin \
	n_tests++; \
	if ((sn) !== (ex)) begin \
		failures++; \
		$display("[FAIL] %s exp %0h got %0h", nm, ex, sn); \
	end \
end
module lfosc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [9:0]  s_axi_awaddr_i = 10'h000;
	logic        s_axi_awvalid_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b1;
	logic [9:0]  s_axi_araddr_i = 10'h000;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b1;
	logic        sysclk_lp_sel_i = 1'b0;
	wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire         s_axi_arready_o, s_axi_rvalid_o, lf_osc_o, lp_osc_en_o;
	wire         crystal_pin_a_en_o, crystal_pin_b_en_o;
	wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	wire  [31:0] s_axi_rdata_o;
	logic [65:0] rq[$];
	logic [65:0] ent;
	logic [1:0]  bq[$];
	logic [1:0]  bx;
	logic [31:0] v, a, b, c, e, f;
	int          failures = 0, n_tests = 0, seed = 58101, hp, n, t;
	time         t0;
	lfosc_ctrl u_dut (.*);
	always #2 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		if (s_axi_rvalid_o === 1'b1) begin
			ent = rq.pop_front();
			`CHK("rresp", ent[65:64], s_axi_rresp_o)
			`CHK("rdata", ent[31:0], s_axi_rdata_o & ent[63:32])
		end
		if (s_axi_bvalid_o === 1'b1) begin
			bx = bq.pop_front();
			`CHK("bresp", bx, s_axi_bresp_o)
		end
	end
	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] rs = `LFOSC_RESP_OKAY);
		@(posedge ref_clk_i);
		bq.push_back(rs);
		s_axi_awaddr_i <= {ad, 2'b00};
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		fork
			begin
				do @(posedge ref_clk_i); while (s_axi_awready_o !== 1'b1);
				s_axi_awvalid_i <= 1'b0;
			end
			begin
				do @(posedge ref_clk_i); while (s_axi_wready_o !== 1'b1);
				s_axi_wvalid_i <= 1'b0;
			end
		join
		do @(posedge ref_clk_i); while (s_axi_bvalid_o !== 1'b1);
	endtask
	// mask 0 keeps only the response check, for polling reads
	task automatic rd(input logic [7:0] ad, input logic [1:0] rs,
		input logic [31:0] mk, ex, output logic [31:0] q);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= {ad, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		rq.push_back({rs, mk, ex & mk});
		do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge ref_clk_i); while (s_axi_rvalid_o !== 1'b1);
		q = s_axi_rdata_o;
	endtask
	task automatic gap(output int nc);
		@(lf_osc_o);
		t0 = $time;
		@(lf_osc_o);
		nc = int'(($time - t0) / 4);
	endtask
	initial begin
		#400000;
		failures++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'hff, 32'h20, v);
		rd(8'h00, `LFOSC_RESP_SLVERR, 32'hffffffff, 32'h0, v);
		wr(8'h00, 32'h0, `LFOSC_RESP_SLVERR);
		for (int m = 0; m < 8; m++) begin
			if (m != 1) begin
				wr(`LFOSC_REG_XCTRL, m << 4);
				rd(`LFOSC_REG_XCTRL, `LFOSC_RESP_OKAY, 32'h70, m << 4, v);
				repeat (3) @(posedge ref_clk_i);
				`CHK("pin_a", m > 5, crystal_pin_a_en_o)
				`CHK("pin_b", m > 1, crystal_pin_b_en_o)
			end
		end
		wr(`LFOSC_REG_MISC, 32'h3);
		for (int i = 0; i < 12; i++) begin
			v = $random(seed);
			sysclk_lp_sel_i <= v[0];
			repeat (8) @(posedge ref_clk_i);
			`CHK("lp_en", sysclk_lp_sel_i, lp_osc_en_o)
		end
		sysclk_lp_sel_i <= 1'b0;
		wr(`LFOSC_REG_MISC, 32'h7);
		repeat (8) @(posedge ref_clk_i);
		`CHK("lp_force", 1'b1, lp_osc_en_o)
		wr(`LFOSC_REG_MISC, 32'h3);
		repeat (8) @(posedge ref_clk_i);
		`CHK("lp_off", 1'b0, lp_osc_en_o)
		v = $random(seed);
		t = v[1:0];
		hp = `LFOSC_PER_BASE + t * `LFOSC_PER_STEP;
		wr(`LFOSC_REG_CTRL, 32'h03 | t << 2);
		n = int'($time / 4);
		wr(`LFOSC_REG_CTRL, 32'h83 | t << 2);
		rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'h40, 32'h0, v);
		do begin
			repeat (400) @(posedge ref_clk_i);
			rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'h0, 32'h0, v);
		end while (v[6] !== 1'b1);
		n = int'($time / 4) - n;
		`CHK("rdy_t", 1'b1, n >= 16 * hp && n < 16 * hp + 500)
		gap(n);
		`CHK("half", hp, n)
		wr(`LFOSC_REG_CTRL, 32'h03 | t << 2);
		rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'hff, 32'h43 | t << 2, v);
		repeat (10) @(posedge ref_clk_i);
		v[0] = lf_osc_o;
		repeat (4000) @(posedge ref_clk_i);
		`CHK("idle", v[0], lf_osc_o)
		wr(`LFOSC_REG_CTRL, 32'h83 | t << 2);
		rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'hff, 32'hc3 | t << 2, v);
		for (int d = 0; d < 3; d++) begin
			wr(`LFOSC_REG_CTRL, 32'h80 | t << 2 | d);
			rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'hff,
				32'h80 | t << 2 | d, v);
			gap(n);
			`CHK("half_div", hp << (3 - d), n)
		end
		@(negedge lf_osc_o);
		rd(`LFOSC_REG_TMR2, `LFOSC_RESP_OKAY, 32'h0, 32'h0, a);
		rd(`LFOSC_REG_TMR3, `LFOSC_RESP_OKAY, 32'h0, 32'h0, b);
		@(posedge lf_osc_o);
		rd(`LFOSC_REG_TMR2, `LFOSC_RESP_OKAY, 32'h0, 32'h0, c);
		rd(`LFOSC_REG_TMR3, `LFOSC_RESP_OKAY, 32'h0, 32'h0, e);
		@(negedge lf_osc_o);
		rd(`LFOSC_REG_TMR2, `LFOSC_RESP_OKAY, 32'h0, 32'h0, f);
		`CHK("t2_hold", a[15:0], c[15:0])
		`CHK("t2_per", 16'(4 * hp), 16'(f[15:0] - a[15:0]))
		`CHK("t3_per", 16'(4 * hp), 16'(e[15:0] - b[15:0]))
		// reset in mid-run must drop ready and restore the control word
		rstn_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(`LFOSC_REG_CTRL, `LFOSC_RESP_OKAY, 32'hff, 32'h20, v);
		print_verdict();
	end
endmodule

// [tb/lfosc_ctrl_properties.sv]
/*
 checker for lfosc_ctrl: run and stop of the oscillator, ready flag, pin
 use and low-power enable, judged from shadow copies of register writes.
 assumes aw and w are offered together and bready and rready stay high.
*/
`include "lfosc_defs.vh"
module lfosc_ctrl_props (
	input logic        ref_clk_i,
	input logic        rstn_i,
	input logic [9:0]  s_axi_awaddr_i,
	input logic        s_axi_awvalid_i,
	input logic        s_axi_awready_o,
	input logic [31:0] s_axi_wdata_i,
	input logic [3:0]  s_axi_wstrb_i,
	input logic        s_axi_wvalid_i,
	input logic        s_axi_wready_o,
	input logic [9:0]  s_axi_araddr_i,
	input logic        s_axi_arvalid_i,
	input logic        s_axi_arready_o,
	input logic [31:0] s_axi_rdata_o,
	input logic        s_axi_rvalid_o,
	input logic        sysclk_lp_sel_i,
	input logic        lf_osc_o,
	input logic        lp_osc_en_o,
	input logic        crystal_pin_a_en_o,
	input logic        crystal_pin_b_en_o
);
	logic [15:0] since;
	logic [15:0] quiet;
	logic [2:0]  xm;
	logic [1:0]  dv;
	logic        en;
	logic        frc;
	logic        ar3;
	logic        held;
	wire         wr = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i
		& s_axi_wready_o & s_axi_wstrb_i[0];
	wire         w3 = wr && s_axi_awaddr_i[9:2] == `LFOSC_REG_CTRL;
	wire         dchg = w3 && s_axi_wdata_i[1:0] != dv;
	wire         rd3 = s_axi_rvalid_o && ar3;
	// only a divider change restarts since: re-enabling keeps the ready flag
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			since <= 16'h0000;
			quiet <= 16'h0000;
			xm    <= 3'h0;
			dv    <= 2'h0;
			en    <= 1'b0;
			frc   <= 1'b0;
			ar3   <= 1'b0;
			held  <= 1'b0;
		end else begin
			if (w3) begin
				en <= s_axi_wdata_i[`LFOSC_B_EN];
				dv <= s_axi_wdata_i[1:0];
			end
			if (wr && s_axi_awaddr_i[9:2] == `LFOSC_REG_XCTRL)
				xm <= s_axi_wdata_i[6:4];
			if (wr && s_axi_awaddr_i[9:2] == `LFOSC_REG_MISC)
				frc <= s_axi_wdata_i[`LFOSC_M_LPSEL];
			if (s_axi_arvalid_i && s_axi_arready_o)
				ar3 <= s_axi_araddr_i[9:2] == `LFOSC_REG_CTRL;
			held <= !dchg && (held || (rd3 && s_axi_rdata_o[6]));
			if (dchg)
				since <= 16'h0000;
			else if (since != 16'h5dc0)
				since <= since + 16'h0001;
			if (!en || $changed(lf_osc_o))
				quiet <= 16'h0000;
			else
				quiet <= quiet + 16'h0001;
		end
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_osc_idle_still: assert property (
		!en [*8] |-> $stable(lf_osc_o))
		else $error("oscillator moved while disabled");
	a_osc_keeps_running: assert property (
		quiet < 16'h6978)
		else $error("oscillator stuck while enabled");
	a_ready_not_early: assert property (
		rd3 && since < 16'h5dc0 |-> !s_axi_rdata_o[6])
		else $error("ready read before stabilization count");
	a_ready_stays_set: assert property (
		rd3 && held |-> s_axi_rdata_o[6])
		else $error("ready cleared without divider change");
	a_lp_select_on: assert property (
		sysclk_lp_sel_i [*8] |-> lp_osc_en_o)
		else $error("low-power oscillator off while selected");
	a_lp_unused_off: assert property (
		(!sysclk_lp_sel_i && !frc) [*8] |-> !lp_osc_en_o)
		else $error("low-power oscillator on while unused");
	a_pin_a_crystal: assert property (
		$stable(xm) [*4] |-> crystal_pin_a_en_o == (xm > 3'h5))
		else $error("crystal pin a use does not follow mode");
	a_pin_b_used: assert property (
		(xm != 3'h1 && $stable(xm)) [*4] |->
		crystal_pin_b_en_o == (xm > 3'h1))
		else $error("crystal pin b use does not follow mode");
endmodule

bind lfosc_ctrl lfosc_ctrl_props u_props (.*);
